// ---- rtl/sdcp_pkg.sv ----
// Constants and types shared by the single-pin debug command port.
// Assumes one system clock; the pin is sampled synchronously.
// Function
// - One open-drain pin, never both directions.
// - Bytes framed as standard async serial characters.
// - Protected register reads only in F00H-FFFH.
// - Protected: refuse 0AH-0DH and 10H-12H.
// - Checksum command 0EH always allowed.
// - Command 00H returns revision major then minor.
// - Command 01H loads counter, high byte first.
// - Counter write discarded unless processor halted.
// - Command 02H returns one status byte.
// - Counter counts cycles, requests break at zero.
package sdcp_pkg;
    localparam logic [7:0] CMD_REV = 8'h00;
    localparam logic [7:0] CMD_WR_CNT = 8'h01;
    localparam logic [7:0] CMD_STATUS = 8'h02;
    localparam logic [7:0] CMD_RD_CNT = 8'h03;
    localparam logic [7:0] CMD_RD_REG = 8'h09;
    localparam logic [7:0] CMD_MEM_LO = 8'h0a;
    localparam logic [7:0] CMD_MEM_HI = 8'h0d;
    localparam logic [7:0] CMD_CRC = 8'h0e;
    localparam logic [7:0] CMD_RSVD = 8'h0f;
    localparam logic [7:0] CMD_INS_LO = 8'h10;
    localparam logic [7:0] CMD_INS_HI = 8'h12;
    localparam logic [3:0] PERIPH_PAGE = 4'hf;
    localparam logic [15:0] REVISION = 16'h0001; // Arbitrary value.
    localparam logic [15:0] BIT_CYCLES = 16'h0d90; // 57600 baud at 200 MHz.
    localparam logic [15:0] CNT_RESET = 16'h0000;
    typedef enum logic [2:0] {
        SDCP_CMD = 3'b000,
        SDCP_OP1 = 3'b001,
        SDCP_OP2 = 3'b010,
        SDCP_SEND = 3'b011,
        SDCP_WAIT = 3'b100
    } sdcp_state_t;
endpackage

// ---- rtl/sdcp_uart.sv ----
// Half-duplex 8N1 character engine for the debug pin.
// Assumes the pin input is already synchronous and idles high.
`timescale 1ns/1ps
`default_nettype none
module sdcp_uart #(
    parameter logic [15:0] BIT_CYC = sdcp_pkg::BIT_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic pin_in,
    input wire logic tx_go_in,
    input wire logic [7:0] tx_byte_in,
    output logic tx_busy_out,
    output logic pin_oe_out,
    output logic rx_valid_out,
    output logic [7:0] rx_byte_out
);
    logic [15:0] rx_cnt_r;
    logic [3:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_act_r;
    logic [15:0] tx_cnt_r;
    logic [3:0] tx_bit_r;
    logic [9:0] tx_sh_r;
    ////////////////////////////////////////////////////////////////////////
    // Receiver samples mid-bit; it is deaf while sending, since its own
    // drive would otherwise echo back.
    always_ff @(posedge mclk_in) begin
        rx_valid_out <= 1'b0;
        if (!rstn_in) begin
            rx_act_r <= 1'b0;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_byte_out <= 8'h00;
        end else if (!rx_act_r) begin
            if (!pin_in && !tx_busy_out) begin
                rx_act_r <= 1'b1;
                rx_cnt_r <= {1'b0, BIT_CYC[15:1]};
                rx_bit_r <= 4'h0;
            end
        end else if (rx_cnt_r != 16'h0000) begin
            rx_cnt_r <= rx_cnt_r - 16'h0001;
        end else begin
            rx_cnt_r <= BIT_CYC - 16'h0001;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0 && pin_in) begin
                rx_act_r <= 1'b0;
            end else if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8) begin
                rx_sh_r <= {pin_in, rx_sh_r[7:1]};
            end else if (rx_bit_r == 4'h9) begin
                rx_act_r <= 1'b0;
                if (pin_in) begin
                    rx_valid_out <= 1'b1;
                    rx_byte_out <= rx_sh_r;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            tx_busy_out <= 1'b0;
            tx_cnt_r <= 16'h0000;
            tx_bit_r <= 4'h0;
            tx_sh_r <= 10'h3ff;
            pin_oe_out <= 1'b0;
        end else if (!tx_busy_out) begin
            pin_oe_out <= 1'b0;
            if (tx_go_in && !rx_act_r) begin
                tx_busy_out <= 1'b1;
                tx_sh_r <= {1'b1, tx_byte_in, 1'b0};
                tx_cnt_r <= BIT_CYC - 16'h0001;
                tx_bit_r <= 4'h0;
                pin_oe_out <= 1'b1;
            end
        end else if (tx_cnt_r != 16'h0000) begin
            tx_cnt_r <= tx_cnt_r - 16'h0001;
        end else if (tx_bit_r == 4'h9) begin
            tx_busy_out <= 1'b0;
            pin_oe_out <= 1'b0;
        end else begin
            tx_cnt_r <= BIT_CYC - 16'h0001;
            tx_bit_r <= tx_bit_r + 4'h1;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            pin_oe_out <= ~tx_sh_r[1];
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sdcp_port.sv ----
// Command decoder, counter and response sequencer of the debug port.
// Assumes halt, protect and status come from the debugger core.
`timescale 1ns/1ps
`default_nettype none
module sdcp_port #(
    parameter logic [15:0] BIT_CYC = sdcp_pkg::BIT_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic dbg_pin_in,
    output logic dbg_pin_out,
    output logic dbg_pin_oe_out,
    input wire logic halted_in,
    input wire logic read_protect_in,
    input wire logic [7:0] debug_status_byte_in,
    input wire logic count_enable_in,
    output logic break_request_out,
    output logic [15:0] debug_cycle_counter_out,
    output logic [7:0] cmd_out,
    output logic [15:0] operand_out,
    output logic cmd_valid_out,
    output logic cmd_refused_out
);
    sdcp_pkg::sdcp_state_t st_r;
    logic [7:0] cmd_r;
    logic [7:0] hi_r;
    logic [15:0] resp_r;
    logic resp_two_r;
    logic tx_go_r;
    logic tx_busy;
    logic pin_oe;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic prot_block;
    logic [7:0] nops;
    sdcp_uart #(.BIT_CYC(BIT_CYC)) u_uart (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .pin_in(dbg_pin_in),
        .tx_go_in(tx_go_r),
        .tx_byte_in(resp_r[15:8]),
        .tx_busy_out(tx_busy),
        .pin_oe_out(pin_oe),
        .rx_valid_out(rx_valid),
        .rx_byte_out(rx_byte)
    );
    ////////////////////////////////////////////////////////////////////////
    // Operand counts: counter write and register read take two bytes.
    always_comb begin
        nops = 8'h00;
        if (rx_byte == sdcp_pkg::CMD_WR_CNT ||
                rx_byte == sdcp_pkg::CMD_RD_REG) begin
            nops = 8'h02;
        end
    end
    // Protected register reads pass only for the peripheral page.
    assign prot_block = read_protect_in &&
        (((cmd_r == sdcp_pkg::CMD_RD_REG) &&
          (hi_r[3:0] != sdcp_pkg::PERIPH_PAGE)) ||
         (cmd_r >= sdcp_pkg::CMD_MEM_LO &&
          cmd_r <= sdcp_pkg::CMD_MEM_HI) ||
         (cmd_r >= sdcp_pkg::CMD_INS_LO &&
          cmd_r <= sdcp_pkg::CMD_INS_HI));
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_in) begin
        tx_go_r <= 1'b0;
        cmd_valid_out <= 1'b0;
        cmd_refused_out <= 1'b0;
        if (!rstn_in) begin
            st_r <= sdcp_pkg::SDCP_CMD;
            cmd_r <= 8'h00;
            hi_r <= 8'h00;
            resp_r <= 16'h0000;
            resp_two_r <= 1'b0;
            cmd_out <= 8'h00;
            operand_out <= 16'h0000;
        end else begin
            unique case (st_r)
                sdcp_pkg::SDCP_CMD: begin
                    if (rx_valid) begin
                        cmd_r <= rx_byte;
                        hi_r <= 8'h00;
                        if (nops != 8'h00) begin
                            st_r <= sdcp_pkg::SDCP_OP1;
                        end else if (rx_byte == sdcp_pkg::CMD_REV) begin
                            resp_r <= sdcp_pkg::REVISION;
                            resp_two_r <= 1'b1;
                            st_r <= sdcp_pkg::SDCP_SEND;
                        end else if (rx_byte == sdcp_pkg::CMD_STATUS) begin
                            resp_r <= {debug_status_byte_in, 8'h00};
                            resp_two_r <= 1'b0;
                            st_r <= sdcp_pkg::SDCP_SEND;
                        end else if (rx_byte == sdcp_pkg::CMD_RD_CNT) begin
                            resp_r <= debug_cycle_counter_out;
                            resp_two_r <= 1'b1;
                            st_r <= sdcp_pkg::SDCP_SEND;
                        end else if (rx_byte >= sdcp_pkg::CMD_MEM_LO &&
                                rx_byte <= sdcp_pkg::CMD_INS_HI &&
                                rx_byte != sdcp_pkg::CMD_RSVD) begin
                            st_r <= sdcp_pkg::SDCP_OP2;
                        end
                        // Reserved codes leave the state untouched.
                    end
                end
                sdcp_pkg::SDCP_OP1: begin
                    if (rx_valid) begin
                        hi_r <= rx_byte;
                        st_r <= sdcp_pkg::SDCP_OP2;
                    end
                end
                sdcp_pkg::SDCP_OP2: begin
                    // Commands without operands pass through at once.
                    if (rx_valid || nops_of(cmd_r) == 1'b0) begin
                        cmd_out <= cmd_r;
                        operand_out <= {hi_r, rx_byte};
                        if (cmd_r != sdcp_pkg::CMD_WR_CNT) begin
                            cmd_valid_out <= !prot_block;
                            cmd_refused_out <= prot_block;
                        end
                        st_r <= sdcp_pkg::SDCP_CMD;
                    end
                end
                sdcp_pkg::SDCP_SEND: begin
                    // Sending starts only once the last byte was taken.
                    if (!tx_busy && !tx_go_r) begin
                        tx_go_r <= 1'b1;
                        st_r <= sdcp_pkg::SDCP_WAIT;
                    end
                end
                sdcp_pkg::SDCP_WAIT: begin
                    if (!tx_busy && !tx_go_r) begin
                        if (resp_two_r) begin
                            resp_two_r <= 1'b0;
                            resp_r <= {resp_r[7:0], 8'h00};
                            st_r <= sdcp_pkg::SDCP_SEND;
                        end else begin
                            st_r <= sdcp_pkg::SDCP_CMD;
                        end
                    end
                end
                default: st_r <= sdcp_pkg::SDCP_CMD;
            endcase
        end
    end
    function automatic logic nops_of(input logic [7:0] c);
        nops_of = (c == sdcp_pkg::CMD_WR_CNT || c == sdcp_pkg::CMD_RD_REG);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // A write wins over counting in the same cycle.
    always_ff @(posedge mclk_in) begin
        break_request_out <= 1'b0;
        if (!rstn_in) begin
            debug_cycle_counter_out <= sdcp_pkg::CNT_RESET;
        end else if (st_r == sdcp_pkg::SDCP_OP2 && rx_valid &&
                cmd_r == sdcp_pkg::CMD_WR_CNT) begin
            if (halted_in) begin
                debug_cycle_counter_out <= {hi_r, rx_byte};
            end
        end else if (count_enable_in &&
                debug_cycle_counter_out != 16'h0000) begin
            debug_cycle_counter_out <= debug_cycle_counter_out - 16'h0001;
            break_request_out <= (debug_cycle_counter_out == 16'h0001);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Open drain: the pin only ever pulls low.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            dbg_pin_out <= 1'b0;
            dbg_pin_oe_out <= 1'b0;
        end else begin
            dbg_pin_out <= 1'b0;
            dbg_pin_oe_out <= pin_oe;
        end
    end
endmodule
`default_nettype wire

// ---- tb/sdcp_port_assertions.sv ----
// Checker for the debug command port, bound to its top module.
// Assumes the protect and halt levels are held steady around commands.
`timescale 1ns/1ps
`default_nettype none
module sdcp_port_assertions #(
    parameter logic [15:0] BIT_CYC = sdcp_pkg::BIT_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic dbg_pin_in,
    input wire logic dbg_pin_out,
    input wire logic dbg_pin_oe_out,
    input wire logic halted_in,
    input wire logic read_protect_in,
    input wire logic count_enable_in,
    input wire logic break_request_out,
    input wire logic [15:0] debug_cycle_counter_out,
    input wire logic [7:0] cmd_out,
    input wire logic [15:0] operand_out,
    input wire logic cmd_valid_out,
    input wire logic cmd_refused_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    pin_low_only_a: assert property (
        !dbg_pin_out) else $error("pin data not low");
    start_idle_a: assert property (
        $rose(dbg_pin_oe_out) |-> $past(dbg_pin_in))
        else $error("drive began while host held pin");
    verdict_excl_a: assert property (
        !(cmd_valid_out && cmd_refused_out)) else $error("both verdicts");
    refuse_prot_a: assert property (
        cmd_refused_out |-> $past(read_protect_in))
        else $error("refused without protect");
    crc_free_a: assert property (
        cmd_refused_out |-> cmd_out != sdcp_pkg::CMD_CRC)
        else $error("checksum refused");
    reg_window_a: assert property (
        cmd_valid_out && read_protect_in && cmd_out == sdcp_pkg::CMD_RD_REG
        |-> operand_out[11:8] == sdcp_pkg::PERIPH_PAGE)
        else $error("protected read outside window");
    break_zero_a: assert property (
        break_request_out |-> debug_cycle_counter_out == 16'h0000
        && $past(debug_cycle_counter_out) == 16'h0001)
        else $error("break not at zero");
    hold_count_a: assert property (
        !halted_in && !count_enable_in |=> $stable(debug_cycle_counter_out))
        else $error("counter changed while running");
    valid_pulse_a: assert property (
        cmd_valid_out |=> !cmd_valid_out) else $error("valid not a pulse");
endmodule
bind sdcp_port sdcp_port_assertions #(.BIT_CYC(BIT_CYC)) chk (.mclk_in,
    .rstn_in, .dbg_pin_in, .dbg_pin_out, .dbg_pin_oe_out, .halted_in,
    .read_protect_in, .count_enable_in, .break_request_out,
    .debug_cycle_counter_out, .cmd_out, .operand_out, .cmd_valid_out,
    .cmd_refused_out);
`default_nettype wire

// ---- tb/sdcp_host.sv ----
// Debug host model: frames bytes onto the pin and reads answers back.
// Assumes an external pull-up; the model only ever pulls low.
`timescale 1ns/1ps
`default_nettype none
module sdcp_host #(
    parameter int BIT = 8
) (
    input wire logic mclk_in,
    input wire logic pin_in,
    output logic oe_out
);
    initial oe_out = 1'b0;
    // Start low, data LSB first, stop high.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            oe_out <= ~f[i]; // Only pulls low; stop leaves pin free.
            repeat (BIT) @(posedge mclk_in);
        end
    endtask
    // Unknown result if no start bit shows, so a silent port fails.
    task automatic recv(output logic [7:0] b);
        int n;
        n = 0;
        b = 8'hxx;
        while (pin_in !== 1'b0 && n < 40 * BIT) begin
            @(posedge mclk_in);
            n++;
        end
        if (n < 40 * BIT) begin
            repeat (BIT / 2) @(posedge mclk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge mclk_in);
                b[i] = pin_in;
            end
            // Wait past the stop bit, so the port is listening again.
            repeat (BIT + BIT / 2) @(posedge mclk_in);
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/sdcp_port_bench.sv ----
// Testbench for the debug command port with a host model on the pin.
// Assumes the short bit time of 8 clocks per serial bit.
`timescale 1ns/1ps
`default_nettype none
module sdcp_port_bench;
    localparam int BIT = 8;
    logic mclk_in, rstn_in, halted_in, read_protect_in, count_enable_in;
    logic dbg_pin_out, dbg_pin_oe_out, host_oe, break_request_out;
    logic cmd_valid_out, cmd_refused_out;
    logic [7:0] debug_status_byte_in, cmd_out, rx, hi;
    logic [15:0] debug_cycle_counter_out, operand_out;
    wire logic pin;
    int fail_count = 0, checks = 0, cycles = 0;
    int n_val = 0, n_ref = 0, n_brk = 0, n_oe = 0;
    assign pin = ~(dbg_pin_oe_out | host_oe);
    sdcp_port #(.BIT_CYC(16'h0008)) dut (.mclk_in, .rstn_in,
        .dbg_pin_in(pin), .dbg_pin_out, .dbg_pin_oe_out, .halted_in,
        .read_protect_in, .debug_status_byte_in, .count_enable_in,
        .break_request_out, .debug_cycle_counter_out, .cmd_out,
        .operand_out, .cmd_valid_out, .cmd_refused_out);
    sdcp_host #(.BIT(BIT)) host (.mclk_in, .pin_in(pin), .oe_out(host_oe));
    ////////////////////////////////////////
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        n_val <= n_val + int'(cmd_valid_out === 1'b1);
        n_ref <= n_ref + int'(cmd_refused_out === 1'b1);
        n_brk <= n_brk + int'(break_request_out === 1'b1);
        n_oe <= n_oe + int'(dbg_pin_oe_out !== 1'b0);
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_cnt(input logic [15:0] v);
        host.send(sdcp_pkg::CMD_WR_CNT);
        host.send(v[15:8]);
        host.send(v[7:0]);
        repeat (4 * BIT) @(posedge mclk_in);
    endtask
    task automatic test_answers();
        debug_status_byte_in <= 8'ha5;
        host.send(sdcp_pkg::CMD_REV);
        host.recv(hi);
        host.recv(rx);
        check({hi, rx}, sdcp_pkg::REVISION);
        host.send(sdcp_pkg::CMD_STATUS);
        host.recv(rx);
        check(rx, 8'ha5);
    endtask
    task automatic test_counter();
        int b0;
        halted_in <= 1'b1;
        wr_cnt(16'h1234);
        host.send(sdcp_pkg::CMD_RD_CNT);
        host.recv(hi);
        host.recv(rx);
        check({hi, rx}, 16'h1234);
        halted_in <= 1'b0;
        wr_cnt(16'h5678);
        check(debug_cycle_counter_out, 16'h1234);
        halted_in <= 1'b1;
        wr_cnt(16'h0005);
        b0 = n_brk;
        count_enable_in <= 1'b1;
        repeat (12) @(posedge mclk_in);
        count_enable_in <= 1'b0;
        check(debug_cycle_counter_out, 16'h0000);
        check(16'(n_brk - b0), 16'h0001);
    endtask
    // Sends one command, then counts verdict pulses and pin drive.
    task automatic one(input logic [7:0] c, input logic [1:0] exp);
        int v0, r0, o0;
        v0 = n_val;
        r0 = n_ref;
        o0 = n_oe;
        host.send(c);
        if (c == sdcp_pkg::CMD_RD_REG) begin
            host.send(exp[0] ? 8'h0e : 8'h0f);
            host.send(8'h20);
        end
        repeat (4 * BIT) @(posedge mclk_in);
        check({8'(n_val - v0), 8'(n_ref - r0)},
            {7'h00, exp[1], 7'h00, exp[0]});
        if (exp != 2'b00) begin
            check(cmd_out, c);
        end
        check(16'(n_oe - o0), 16'h0000);
    endtask
    task automatic test_protect();
        logic [7:0] codes [9] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11,
            8'h12, 8'h0e, 8'h0f};
        read_protect_in <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            one(codes[i], {i == 7, i < 7});
        end
        one(sdcp_pkg::CMD_RD_REG, 2'b01); // Page E is outside.
        one(sdcp_pkg::CMD_RD_REG, 2'b10); // Page F is allowed.
        check(operand_out, 16'h0f20);
        read_protect_in <= 1'b0;
        one(8'h0a, 2'b10);
        one(8'h13, 2'b00);
        one(8'hff, 2'b00);
    endtask
    initial begin
        rstn_in = 1'b0;
        halted_in = 1'b0;
        read_protect_in = 1'b0;
        count_enable_in = 1'b0;
        debug_status_byte_in = 8'h00;
        repeat (3) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        test_answers();
        test_counter();
        test_protect();
        print_verdict();
    end
endmodule
`default_nettype wire
